// ### src/ebsw_top.sv
// External bus strobe, wait and hold control with AHB-Lite registers.
// Assumes bclk, ready, hold request and read data come from pins.
//
// Summary of operation
// - wide bus picks strobe set by mode bit
// - combined strobe set selected after reset
// - separate stores encode read, even, odd, word
// - lane enable with address bit picks bytes
// - address goes out with the latch pulse
// - ready sampled at bus clock falling edge
// - ready honoured only for waited areas
// - bus outputs freeze during ready wait
// - ready ignored just before software wait
// - hold taken after current access ends
// - grant acknowledge low while hold lasts
// - hold beats DMA beats core
// - bus outputs float in hold
// - watchdog stops in hold, latch held low
// - area wait bit zero inserts a wait
// - wait bits 4 to 7 map areas 0-3
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps

module ebsw_top
  import ebsw_pkg::*;
#(
  parameter int AW = 20,
  parameter int DW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cke,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic bclk_pin,
  input wire logic byte_mode_pin,
  input wire logic ready_pin,
  input wire logic hold_req_n_pin,
  input wire logic [DW-1:0] data_in,
  input wire logic dma_req,
  input wire logic dma_write,
  input wire logic dma_word,
  input wire logic [AW-1:0] dma_addr,
  input wire logic [DW-1:0] dma_wdata,
  input wire logic [1:0] dma_area,
  output logic dma_done,
  output logic [DW-1:0] dma_rdata,
  output logic rd_n,
  output logic wr_n,
  output logic low_lane_store_n,
  output logic high_lane_store_n,
  output logic upper_lane_enable_n,
  output logic [AW-1:0] addr_out,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  output logic bus_oe,
  output logic [3:0] area_sel_n,
  output logic ale,
  output logic bus_grant_ack_n,
  output logic port_lo_oe,
  output logic port_freeze,
  output logic wdt_run
);

  // Refuse sizes the logic cannot serve
  if (AW < 16 || AW > 32) begin : g_bad_aw
    $error("ebsw_top: AW out of range");
  end
  if (DW != 16) begin : g_bad_dw
    $error("ebsw_top: DW must be 16");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic bclk_s; // Filtered bus clock level
  logic bclk_d; // Previous filtered level
  logic byte_s; // Narrow bus select
  logic ready_s; // Ready, low asks for wait
  logic hold_n_s; // Hold request, active low
  logic [DW-1:0] din_s; // Read data from the bus

  ebsw_sync #(.W(4)) u_sync_ctl (
    .hclk(hclk),
    .hresetn(hresetn),
    .cke(cke),
    .d({bclk_pin, byte_mode_pin, ready_pin, hold_req_n_pin}),
    .q({bclk_s, byte_s, ready_s, hold_n_s})
  );

  ebsw_sync #(.W(DW)) u_sync_dat (
    .hclk(hclk),
    .hresetn(hresetn),
    .cke(cke),
    .d(data_in),
    .q(din_s)
  );

  // Bus clock edge finder
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bclk_d <= 1'b0;
    end else if (cke) begin
      bclk_d <= bclk_s;
    end
  end

  logic b_rise; // Bus clock rising event
  logic b_fall; // Bus clock falling event
  assign b_rise = bclk_s && !bclk_d;
  assign b_fall = !bclk_s && bclk_d;

  // ----------------------------------------------------------------
  // AHB-Lite register slave
  // ----------------------------------------------------------------
  logic [7:0] mode0; // Processor mode bits
  logic [7:0] area_ctl; // Area enables and wait bits
  logic [7:0] prot; // Write protect bits
  logic [5:0] cmd; // Core access settings
  logic [AW-1:0] core_addr; // Core access address
  logic [DW-1:0] core_wdata; // Core write data
  logic [DW-1:0] core_rdata; // Last core read data
  logic core_pend; // Core access waiting for the bus
  logic wr_ph; // Write data phase pending
  logic [7:0] wr_idx; // Index of the pending write
  logic [7:0] a_idx; // Index of the address phase
  logic a_take; // Address phase taken
  logic mode_wr_fire; // Mode register write accepted
  logic core_start; // Core access granted
  ebsw_state_e state; // Sequencer state
  ebsw_owner_e owner; // Current access owner
  logic rdy_wait; // Ready-driven wait pending

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign a_take = hsel && hready && htrans[1];
  assign a_idx = haddr[9:2];
  assign mode_wr_fire = wr_ph && (wr_idx == `EBSW_IDX_MODE0) &&
                        prot[`EBSW_PROT_MODE];

  // Read value of one register index
  function automatic logic [31:0] reg_read(input logic [7:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (idx)
      `EBSW_IDX_MODE0: v = {24'h00_0000, mode0};
      `EBSW_IDX_AREA: v = {24'h00_0000, area_ctl};
      `EBSW_IDX_PROT: v = {24'h00_0000, prot};
      `EBSW_IDX_CMD: v = {26'h0, cmd};
      `EBSW_IDX_ADDR: v = 32'(core_addr);
      `EBSW_IDX_WDATA: v = {16'h0000, core_wdata};
      `EBSW_IDX_STAT: v = {core_rdata, 12'h000,
                           (state == ST_RWAIT), (state == ST_HOLD),
                           (owner == OWN_CORE), core_pend};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_read

  // Address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      wr_idx <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (cke) begin
      wr_ph <= a_take && hwrite;
      wr_idx <= a_idx;
      if (a_take && !hwrite) begin
        hrdata <= reg_read(a_idx);
      end
    end
  end

  // Software-written registers; mode bit 2 resets to combined set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode0 <= `EBSW_MODE0_RST;
      area_ctl <= `EBSW_AREA_RST;
      prot <= `EBSW_PROT_RST;
      cmd <= 6'h00;
      core_addr <= '0;
      core_wdata <= '0;
    end else if (cke && wr_ph) begin
      case (wr_idx)
        `EBSW_IDX_MODE0: if (mode_wr_fire) mode0 <= hwdata[7:0];
        `EBSW_IDX_AREA: area_ctl <= hwdata[7:0];
        `EBSW_IDX_PROT: prot <= hwdata[7:0];
        `EBSW_IDX_CMD: cmd <= hwdata[5:0];
        `EBSW_IDX_ADDR: core_addr <= hwdata[AW-1:0];
        `EBSW_IDX_WDATA: core_wdata <= hwdata[DW-1:0];
        default: cmd <= cmd;
      endcase
    end
  end

  // Core request flag; a go while one is pending is ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_pend <= 1'b0;
    end else if (cke) begin
      if (core_start) begin
        core_pend <= 1'b0;
      end else if (wr_ph && wr_idx == `EBSW_IDX_CMD &&
                   hwdata[`EBSW_CMD_GO]) begin
        core_pend <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  logic sep; // Separate store strobes in use
  logic [1:0] area; // Area of the current access
  logic acc_write; // Current access writes
  logic acc_word; // Current access moves both lanes
  logic acc_mux; // Current access uses the multiplexed space
  logic [DW-1:0] acc_wdata; // Current write data
  logic area_wait; // Area asks for software wait
  logic sw_need; // Software wait follows the strobe cycle
  logic hold_req; // Hold requested
  logic start; // New access begins
  logic finish; // Access ends at this rising event

  // Strobe set follows mode bit only on a wide bus
  assign sep = mode0[`EBSW_MODE0_SEP] && !byte_s;
  assign area_wait = !area_ctl[`EBSW_AREA_WAIT_LSB + area];
  assign sw_need = area_wait || acc_mux;
  assign hold_req = !hold_n_s;
  // Arbitration: hold, then DMA, then core
  assign start = b_rise && state == ST_IDLE && !hold_req &&
                 (dma_req || core_pend);
  assign core_start = start && !dma_req;
  assign finish = b_rise && !rdy_wait &&
                  ((state == ST_STROBE && !sw_need) ||
                   state == ST_SWAIT || state == ST_RWAIT);

  // State transitions on bus clock rising events
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
    end else if (cke && b_rise) begin
      case (state)
        ST_IDLE: begin
          if (hold_req) begin
            state <= ST_HOLD;
          end else if (start) begin
            state <= (dma_req ? 1'b0 : cmd[`EBSW_CMD_MUX]) ?
                     ST_ALE : ST_STROBE;
          end
        end
        ST_ALE: state <= ST_STROBE;
        ST_STROBE: begin
          if (sw_need) begin
            state <= ST_SWAIT;
          end else if (rdy_wait) begin
            state <= ST_RWAIT;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_SWAIT: state <= rdy_wait ? ST_RWAIT : ST_IDLE;
        ST_RWAIT: if (!rdy_wait) state <= ST_IDLE;
        // Stay while request low, resume from idle a cycle later
        ST_HOLD: if (!hold_req) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Latch the granted access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      owner <= OWN_NONE;
      area <= 2'b00;
      acc_write <= 1'b0;
      acc_word <= 1'b0;
      acc_mux <= 1'b0;
      addr_out <= '0;
      acc_wdata <= '0;
    end else if (cke) begin
      if (start && dma_req) begin
        owner <= OWN_DMA;
        area <= dma_area;
        acc_write <= dma_write;
        acc_word <= dma_word && !byte_s;
        acc_mux <= 1'b0;
        addr_out <= dma_addr;
        acc_wdata <= dma_wdata;
      end else if (core_start) begin
        owner <= OWN_CORE;
        area <= cmd[`EBSW_CMD_AREA_LSB +: 2];
        acc_write <= cmd[`EBSW_CMD_WRITE];
        acc_word <= cmd[`EBSW_CMD_WORD] && !byte_s;
        acc_mux <= cmd[`EBSW_CMD_MUX];
        addr_out <= core_addr;
        acc_wdata <= core_wdata;
      end else if (finish) begin
        owner <= OWN_NONE;
      end
    end
  end

  // Ready sampling at falling events, only where honoured
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_wait <= 1'b0;
    end else if (cke) begin
      if (start) begin
        rdy_wait <= 1'b0;
      end else if (b_fall && area_wait) begin
        if (state == ST_RWAIT) begin
          rdy_wait <= !ready_s;
        end else if (state == ST_SWAIT ||
                     (state == ST_STROBE && !sw_need)) begin
          rdy_wait <= !ready_s;
        end
      end
    end
  end

  // Read data return and DMA completion pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_rdata <= '0;
      dma_rdata <= '0;
      dma_done <= 1'b0;
    end else if (cke) begin
      dma_done <= finish && owner == OWN_DMA;
      if (finish && !acc_write && owner == OWN_DMA) begin
        dma_rdata <= din_s;
      end
      if (finish && !acc_write && owner == OWN_CORE) begin
        core_rdata <= din_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic strobe_act; // Strobes active in this state
  logic out_load; // Outputs may change
  assign strobe_act = state == ST_STROBE || state == ST_SWAIT ||
                      state == ST_RWAIT;
  assign out_load = state != ST_RWAIT;

  ebsw_strobe u_strobe (
    .hclk(hclk),
    .hresetn(hresetn),
    .cke(cke),
    .load(out_load),
    .active(strobe_act && state != ST_HOLD),
    .write(acc_write),
    .word(acc_word),
    .lsb(addr_out[0]),
    .sep(sep),
    .byte_bus(byte_s),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .low_lane_store_n(low_lane_store_n),
    .high_lane_store_n(high_lane_store_n),
    .upper_lane_enable_n(upper_lane_enable_n)
  );

  // Remaining bus pins, frozen in ready wait, released in hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ale <= 1'b0;
      data_out <= '0;
      data_oe <= 1'b0;
      bus_oe <= 1'b1;
      area_sel_n <= 4'hf;
      bus_grant_ack_n <= 1'b1;
      port_lo_oe <= 1'b1;
      port_freeze <= 1'b0;
      wdt_run <= 1'b1;
    end else if (cke) begin
      port_freeze <= state == ST_RWAIT;
      bus_grant_ack_n <= state != ST_HOLD;
      bus_oe <= state != ST_HOLD;
      port_lo_oe <= state != ST_HOLD;
      wdt_run <= state != ST_HOLD;
      if (state == ST_HOLD) begin
        ale <= 1'b0;
        data_oe <= 1'b0;
      end else if (out_load) begin
        // Address rides the data lines with the latch pulse
        ale <= state == ST_ALE;
        data_oe <= state == ST_ALE || (strobe_act && acc_write);
        data_out <= (state == ST_ALE) ? addr_out[DW-1:0] : acc_wdata;
        for (int i = 0; i < 4; i++) begin
          area_sel_n[i] <= !(owner != OWN_NONE && area == 2'(i) &&
                             area_ctl[i]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_SEP_NEEDS_WRITE: assert property (
    $rose(mode0[`EBSW_MODE0_SEP]) |-> $past(mode_wr_fire))
    else $error("strobe set changed without a mode write");
  AST_SEP_NARROW: assert property (
    (byte_s && $past(byte_s) && $past(byte_s, 2)) |->
      (low_lane_store_n && high_lane_store_n))
    else $error("separate stores on a narrow bus");
  AST_READ_STORES: assert property (
    !rd_n |-> (wr_n && low_lane_store_n && high_lane_store_n))
    else $error("store strobe during read");
  AST_ULE_NARROW: assert property (
    (byte_s && $past(byte_s)) |-> upper_lane_enable_n)
    else $error("lane enable used on a narrow bus");
  AST_ALE_ADDR: assert property (
    ale |-> (data_oe && data_out == addr_out[DW-1:0]))
    else $error("latch pulse without address");
  AST_WAIT_FREEZE: assert property (
    (state == ST_RWAIT && $past(state) == ST_RWAIT) |->
      ($stable(addr_out) && $stable(rd_n) && $stable(area_sel_n)))
    else $error("bus moved during ready wait");
  AST_NO_RDY_ALLWAIT: assert property (
    (area_ctl[7:4] == 4'hf) |=> !rdy_wait)
    else $error("ready honoured with all wait bits set");
  AST_NO_RDY_BEFORE_SW: assert property (
    (state == ST_STROBE && sw_need) |-> !rdy_wait)
    else $error("ready taken before software wait");
  AST_HOLD_FROM_IDLE: assert property (
    (state == ST_HOLD && $past(state) != ST_HOLD) |->
      $past(state) == ST_IDLE)
    else $error("hold entered inside an access");
  AST_HOLD_PINS: assert property (
    (state == ST_HOLD) |=> (!bus_grant_ack_n && !bus_oe && !port_lo_oe))
    else $error("hold pins wrong");
  AST_DMA_FIRST: assert property (
    (start && dma_req) |=> owner == OWN_DMA)
    else $error("DMA lost arbitration to core");
  AST_RESUME_GAP: assert property (
    ($past(state) == ST_HOLD && state != ST_HOLD) |->
      (state == ST_IDLE ##1 bus_grant_ack_n))
    else $error("resume without idle cycle");

  COV_READY_WAIT: cover property (state == ST_RWAIT ##1 finish);
  COV_HOLD: cover property (state == ST_HOLD ##1 state == ST_IDLE);
  COV_MUX: cover property (ale ##[1:40] finish);
  COV_SEP_WORD: cover property (!low_lane_store_n && !high_lane_store_n);

endmodule : ebsw_top

// ### src/ebsw_defs.svh
// Constants of the external bus strobe, wait and hold block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef EBSW_DEFS_SVH
`define EBSW_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define EBSW_IDX_MODE0 8'h04
`define EBSW_IDX_AREA 8'h08
`define EBSW_IDX_PROT 8'h0a
`define EBSW_IDX_CMD 8'h10
`define EBSW_IDX_ADDR 8'h11
`define EBSW_IDX_WDATA 8'h12
`define EBSW_IDX_STAT 8'h13

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EBSW_MODE0_SEP 2
`define EBSW_PROT_MODE 1
`define EBSW_AREA_WAIT_LSB 4
`define EBSW_CMD_GO 0
`define EBSW_CMD_WRITE 1
`define EBSW_CMD_WORD 2
`define EBSW_CMD_AREA_LSB 3
`define EBSW_CMD_MUX 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EBSW_MODE0_RST 8'h00
`define EBSW_AREA_RST 8'h01
`define EBSW_PROT_RST 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EBSW_HCLK_NS 40
`define EBSW_SYNC_STAGES 3

`endif

// ### src/ebsw_pkg.sv
// Types shared by the external bus strobe, wait and hold block.
// Assumes the constants header sits beside it.
`include "ebsw_defs.svh"

package ebsw_pkg;

  // Bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ALE, ST_STROBE, ST_SWAIT, ST_RWAIT, ST_HOLD
  } ebsw_state_e;

  // Owner of the current bus access
  typedef enum logic [1:0] {OWN_NONE, OWN_CORE, OWN_DMA} ebsw_owner_e;

endpackage : ebsw_pkg

// ### src/ebsw_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes an input from outside the hclk domain.
`timescale 1ns/1ps

module ebsw_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cke,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic [W-1:0] s1; // Metastable catch, read only by s2
  logic [W-1:0] s2; // Second stage
  logic [W-1:0] s3; // Third stage

  // Refuse a width the chain cannot serve
  if (W < 1) begin : g_bad_w
    $error("ebsw_sync: width must be positive");
  end

  // Shift chain, output updates only when stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else if (cke) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end

endmodule : ebsw_sync

// ### src/ebsw_strobe.sv
// Registered read/write strobe encoder for both strobe sets.
// Assumes the sequencer holds load low while the bus must freeze.
`timescale 1ns/1ps

module ebsw_strobe (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cke,
  input wire logic load,
  input wire logic active,
  input wire logic write,
  input wire logic word,
  input wire logic lsb,
  input wire logic sep,
  input wire logic byte_bus,
  output logic rd_n,
  output logic wr_n,
  output logic low_lane_store_n,
  output logic high_lane_store_n,
  output logic upper_lane_enable_n
);

  // Strobe levels, all inactive while idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      low_lane_store_n <= 1'b1;
      high_lane_store_n <= 1'b1;
      upper_lane_enable_n <= 1'b1;
    end else if (cke && load) begin
      rd_n <= !(active && !write);
      // Single write strobe only in the combined set
      wr_n <= !(active && write && !sep);
      // Separate stores: even lane low, odd lane high, word both
      low_lane_store_n <= !(active && write && sep &&
                            (word || !lsb));
      high_lane_store_n <= !(active && write && sep &&
                             (word || lsb));
      // Upper lane enable only on a wide bus in the combined set
      upper_lane_enable_n <= !(active && !sep && !byte_bus &&
                               (word || lsb));
    end
  end

endmodule : ebsw_strobe

// ### bench/ebsw_ext_model.sv
// Far side of the bus: a memory that echoes the address, and a slow ready.
// Assumes strobes and address come straight from the block's pins.
`timescale 1ns/1ps

module ebsw_ext_model (
  input wire logic bclk,
  input wire logic stall,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [19:0] addr_out,
  output logic [15:0] data_in,
  output logic ready_pin
);
  logic [2:0] falls = 3'h0; // Bus clock falls seen in this access
  logic [15:0] v; // Word the memory holds at this address
  assign v = addr_out[15:0] ^ 16'h5a5a;
  // Lines show the inverse while not read, so stale data cannot match
  assign data_in = rd_n ? ~v : v;
  // Count falls while a strobe is low
  always @(negedge bclk) begin
    if (rd_n && wr_n) begin
      falls <= 3'h0;
    end else if (falls != 3'h7) begin
      falls <= falls + 3'h1;
    end
  end
  // Slow device holds ready low over four falls, else the idle high level
  assign ready_pin = !(stall && !(rd_n && wr_n) && falls < 3'h4);
endmodule : ebsw_ext_model

// ### bench/external_bus_strobe_wait_hold_tb.sv
// Random and corner tests of strobes, waits and hold over AHB-Lite.
// Assumes the partner model stands on the pins.
`timescale 1ns/1ps
`include "ebsw_defs.svh"

module external_bus_strobe_wait_hold_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, bclk = 0, stall = 0;
  logic byte_mode = 0, hold_n = 1, dma_req = 0, got_done = 0, clr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] haddr = 0, hwdata = 0, r, hrdata;
  logic [19:0] dma_addr = 0, addr_out;
  logic [15:0] data_in, dma_rdata, data_out;
  logic [5:0] seen = 0;
  logic [4:0] fz_sel = 0;
  logic [15:0] wcap = 0;
  logic [3:0] area_sel_n;
  logic hreadyout, hresp, ready_pin, dma_done, rd_n, wr_n, wl, wh, ule;
  logic data_oe, bus_oe, ale, ack_n, port_lo_oe, port_freeze, wdt_run;
  int lowcnt = 0, cyc = 0, miscompares = 0, cmp_count = 0, seed = 85342;
  int i, n;
  // Clocks: bus clock free running, offset in phase
  always #20 hclk = ~hclk;
  initial #13 forever #160 bclk = ~bclk;
  ebsw_top u_dut (.hclk(hclk), .hresetn(hresetn), .cke(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .bclk_pin(bclk),
    .byte_mode_pin(byte_mode), .ready_pin(ready_pin),
    .hold_req_n_pin(hold_n), .data_in(data_in), .dma_req(dma_req),
    .dma_write(1'b0), .dma_word(1'b1), .dma_addr(dma_addr),
    .dma_wdata(16'h0), .dma_area(2'h1), .dma_done(dma_done),
    .dma_rdata(dma_rdata), .rd_n(rd_n), .wr_n(wr_n),
    .low_lane_store_n(wl), .high_lane_store_n(wh),
    .upper_lane_enable_n(ule), .addr_out(addr_out), .data_out(data_out),
    .data_oe(data_oe), .bus_oe(bus_oe), .area_sel_n(area_sel_n),
    .ale(ale), .bus_grant_ack_n(ack_n), .port_lo_oe(port_lo_oe),
    .port_freeze(port_freeze), .wdt_run(wdt_run));
  ebsw_ext_model u_mem (.bclk(bclk), .stall(stall), .rd_n(rd_n),
    .wr_n(wr_n), .addr_out(addr_out), .data_in(data_in),
    .ready_pin(ready_pin));
  // Monitor: strobes seen active, read strobe length, timeout
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    seen <= clr ? 6'h0 : seen | ~{rd_n, wr_n, wl, wh, ule, !ale};
    fz_sel <= clr ? 5'h0 : fz_sel | {port_freeze, ~area_sel_n};
    if (data_oe && !(wr_n && wl && wh)) wcap <= data_out;
    lowcnt <= clr ? 0 : lowcnt + int'(!rd_n);
    if (dma_done) got_done <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // Compare one value
  task automatic chk(input logic [31:0] g, x, input string m);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask : chk
  // One AHB-Lite single word transfer; read data lands in r
  task automatic ahb(input logic w, input logic [7:0] idx, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  // Core access through the command register, then strobe check
  task automatic acc(input logic w, wd, lsb, mx, sep, input logic [1:0] ar);
    logic [19:0] a;
    logic [5:0] x, m;
    logic [31:0] wv;
    a = 20'($random(seed));
    wv = $random(seed);
    a[0] = lsb;
    @(posedge hclk) clr <= 1'b1;
    @(posedge hclk) clr <= 1'b0;
    ahb(1, `EBSW_IDX_ADDR, {12'h0, a});
    ahb(1, `EBSW_IDX_WDATA, wv);
    ahb(1, `EBSW_IDX_CMD, {26'h0, mx, ar, wd, w, 1'b1});
    n = 0;
    do begin
      ahb(0, `EBSW_IDX_STAT, 0);
      n++;
    end while (r[1:0] !== 2'h0 && n < 400);
    x = {!w, w, w & (wd | !lsb), w & (wd | lsb), wd | lsb, mx};
    m = sep ? 6'h2d : (byte_mode ? 6'h31 : 6'h33);
    chk(seen & m, x & m, "strobes");
    chk(fz_sel[3:0], 4'h1 << ar, "area select");
    if (w) chk(wcap, wv[15:0], "wdata");
    if (!w && wd && !byte_mode)
      chk(r[31:16], a[15:0] ^ 16'h5a5a, "rdata");
  endtask : acc
  // Verdict and end of run
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({rd_n, wr_n, ack_n, bus_oe, ale, hresp}, 6'h3c, "reset pins");
    ahb(0, `EBSW_IDX_MODE0, 0);
    chk(r, 0, "mode reset");
    ahb(1, `EBSW_IDX_AREA, 32'hff);
    ahb(1, `EBSW_IDX_MODE0, 32'h4);
    ahb(0, `EBSW_IDX_MODE0, 0);
    chk(r[2], 0, "locked mode");
    ahb(1, `EBSW_IDX_PROT, 32'h2);
    ahb(1, `EBSW_IDX_MODE0, 32'h4);
    ahb(0, `EBSW_IDX_MODE0, 0);
    chk(r[2], 1, "sep mode");
    for (i = 0; i < 8; i++) acc(i[0], i[1], i[2] & !i[1], 0, 1, 1);
    ahb(1, `EBSW_IDX_MODE0, 0);
    for (i = 0; i < 8; i++)
      acc(i[0], i[1], i[2] & !i[1], i[2], 0, 2);
    byte_mode <= 1'b1;
    repeat (10) @(posedge hclk);
    acc(0, 1, 0, 0, 0, 2);
    acc(1, 0, 1, 0, 0, 3);
    byte_mode <= 1'b0;
    for (i = 0; i < 4; i++) begin
      ahb(1, `EBSW_IDX_AREA, 32'hff & ~(32'h10 << i));
      acc(0, 1, 0, 0, 0, i[1:0]);
      chk(lowcnt, 16, "soft wait");
      acc(0, 1, 0, 0, 0, i[1:0] ^ 2'h1);
      chk(lowcnt, 8, "no wait");
    end
    stall <= 1'b1;
    acc(0, 1, 0, 0, 0, 2);
    chk(lowcnt, 8, "ready ignored");
    chk(fz_sel[4], 0, "no freeze");
    ahb(1, `EBSW_IDX_AREA, 32'hef);
    acc(0, 1, 0, 0, 0, 0);
    chk(lowcnt > 16, 1, "ready wait");
    chk(fz_sel[4], 1, "freeze");
    stall <= 1'b0;
    hold_n <= 1'b0;
    dma_addr <= 20'($random(seed)) & 20'hffffe;
    repeat (6) @(posedge hclk);
    dma_req <= 1'b1;
    for (n = 0; n < 100 && ack_n !== 1'b0; n++) @(posedge hclk);
    ahb(1, `EBSW_IDX_CMD, 32'h1);
    repeat (40) @(posedge hclk);
    chk({ack_n, bus_oe, port_lo_oe, wdt_run, got_done}, 0,
        "hold");
    hold_n <= 1'b1;
    for (n = 0; n < 100 && ack_n !== 1'b1; n++) @(posedge hclk);
    chk({ack_n, bus_oe, port_lo_oe, wdt_run}, 4'hf, "release");
    for (n = 0; n < 200 && dma_done !== 1'b1; n++) @(posedge hclk);
    dma_req <= 1'b0;
    chk(dma_rdata, dma_addr[15:0] ^ 16'h5a5a, "dma read");
    ahb(0, `EBSW_IDX_STAT, 0);
    chk(r[0], 1, "core waits");
    final_report();
  end
endmodule : external_bus_strobe_wait_hold_tb
